// file: rtl/adc_trigger_sequencer.sv
// Summary of operation
// - clocked source ends sampling when counter expires
// - sample lasts acq_tick_count conversion-clock periods, zero taken as one
// - clocked plus auto repeats sequences continuously
// - source 001 converts on selected pin edge
// - source 010 converts on timer pair match
// - source 011 converts on pwm special event
// - auto plus event converts on each trigger while sampling
// - acq_active bit 1, quantize_active bit 0
// - sampling end sets quantize_active; both zero idle
// - interrupt after every results_per_irq plus one conversions
// - only adc_irq_enable masks the interrupt
// - manual clear ends sampling if auto is off; 000 converts on any clear
// - clearing auto finishes sequence, no restart
// - module_on clear aborts conversion, no write
// - select field bits 7:5; 000 software trigger
// - auto starts sampling whenever not converting
// - results_per_irq holds count minus one
// - buffer writes restart at location zero
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module adc_trigger_sequencer
    import adc_seq_pkg::*;
#(
    parameter int BUF_DEPTH = 16,
    parameter int RESULT_W  = 12
) (
    // clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0]   i_reg_addr,
    input  wire logic [DATA_W-1:0]   i_reg_wdata,
    input  wire logic                i_reg_write,
    input  wire logic                i_reg_read,
    output logic      [DATA_W-1:0]   o_reg_rdata,
    // trigger sources
    input  wire logic                i_ext_irq_pin_zero,
    input  wire logic [31:0]         i_timer_pair_count,
    input  wire logic [31:0]         i_timer_pair_period,
    input  wire logic                i_pwm_special_event,
    // converter side
    output logic                     o_acq_active,
    output logic                     o_quantize_active,
    output logic                     o_quantize_start,
    output logic                     o_quantize_abort,
    input  wire logic                i_quantize_done,
    input  wire logic [RESULT_W-1:0] i_quantize_result,
    // interrupt
    output logic                     o_adc_irq
);
    localparam int PTR_W = $clog2(BUF_DEPTH);

    generate
        if (BUF_DEPTH != 16 || RESULT_W < 1 || RESULT_W > DATA_W) begin : g_bad_param
            $error("adc_trigger_sequencer needs a 16-word buffer and RESULT_W up to DATA_W");
        end
    endgenerate

    // configuration state
    logic                  module_on;
    logic [2:0]            trigger_source_sel;
    logic                  auto_acq_enable;
    logic [4:0]            acq_tick_count;
    logic [3:0]            results_per_irq;
    logic                  adc_irq_enable;
    logic                  edge_rising;

    // sequencing state
    seq_state_e            state;
    seq_state_e            next_state;
    logic [4:0]            tick_left;
    logic [3:0]            seq_count;
    logic [PTR_W-1:0]      wr_ptr;
    logic                  pin_q;
    logic                  match_q;
    logic                  quantize_start;
    logic                  irq_pulse;
    logic [DATA_W-1:0]     rdata;
    logic [RESULT_W-1:0]   result_buffer [BUF_DEPTH];

    // register decode
    wire        wr_ctrl     = i_reg_write && (i_reg_addr == REG_CTRL);
    wire        wr_cfg      = i_reg_write && (i_reg_addr == REG_CFG);
    wire        wr_acq_bit  = i_reg_wdata[CTRL_ACQ_ACTIVE];
    wire        sw_set_acq  = wr_ctrl && wr_acq_bit;
    wire        sw_clr_acq  = wr_ctrl && !wr_acq_bit;
    wire        buf_hit     = (i_reg_addr[ADDR_W-1] == REG_BUF[ADDR_W-1]);
    wire [PTR_W-1:0] rd_idx = i_reg_addr[PTR_W-1:0];

    // trigger edge detection
    wire        pin_edge    = edge_rising ? (i_ext_irq_pin_zero && !pin_q)
                                          : (!i_ext_irq_pin_zero && pin_q);
    wire        timer_match = (i_timer_pair_count == i_timer_pair_period);
    wire        timer_event = timer_match && !match_q;
    logic       trig_event;

    always_comb begin
        trig_event = 1'b0;
        unique case (trigger_source_sel)
            SEL_EXT_PIN: trig_event = pin_edge;
            SEL_TIMER:   trig_event = timer_event;
            SEL_PWM:     trig_event = i_pwm_special_event;
            default:     trig_event = 1'b0;
        endcase
    end

    // sample termination
    wire        quantize_active_tick;
    wire        in_sample   = (state == ST_SAMPLE);
    wire        in_convert  = (state == ST_CONVERT);
    wire        enter_sample = (next_state == ST_SAMPLE) && !in_sample;
    wire [4:0]  tick_load   = (acq_tick_count == 5'h00) ? 5'h01 : acq_tick_count;
    wire        clocked_done = (trigger_source_sel == SEL_CLOCKED) && quantize_active_tick
                               && (tick_left == 5'h01);
    wire        sw_convert  = (trigger_source_sel == SEL_SOFTWARE) && sw_clr_acq;
    wire        go_convert  = module_on && in_sample
                              && (clocked_done || sw_convert || trig_event);
    wire        sw_stop     = sw_clr_acq && !auto_acq_enable;

    // result capture
    wire        buf_we      = in_convert && i_quantize_done && module_on;
    wire        group_end   = (seq_count == results_per_irq);

    quantize_active_tick_divider #(
        .DIV       (QUANTIZE_ACTIVE_CLOCK_CYCLES)
    ) u_tick (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_restart (enter_sample),
        .o_tick    (quantize_active_tick)
    );

    // sequence control
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (module_on && (auto_acq_enable || sw_set_acq)) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (go_convert) begin
                    next_state = ST_CONVERT;
                end else if (sw_stop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CONVERT: begin
                if (i_quantize_done) begin
                    next_state = auto_acq_enable ? ST_SAMPLE : ST_IDLE;
                end
            end
        endcase
        if (!module_on) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // control and configuration registers
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            module_on          <= 1'b0;
            trigger_source_sel <= SEL_RESET;
            auto_acq_enable    <= 1'b0;
        end else if (wr_ctrl) begin
            module_on          <= i_reg_wdata[CTRL_MODULE_ON];
            trigger_source_sel <= i_reg_wdata[CTRL_SEL_LSB +: CTRL_SEL_W];
            auto_acq_enable    <= i_reg_wdata[CTRL_AUTO_ACQ];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            acq_tick_count  <= TICK_RESET;
            results_per_irq <= RPI_RESET;
            adc_irq_enable  <= 1'b0;
            edge_rising     <= 1'b0;
        end else if (wr_cfg) begin
            acq_tick_count  <= i_reg_wdata[CFG_TICK_LSB +: CFG_TICK_W];
            results_per_irq <= i_reg_wdata[CFG_RPI_LSB +: CFG_RPI_W];
            adc_irq_enable  <= i_reg_wdata[CFG_IRQ_ENABLE];
            edge_rising     <= i_reg_wdata[CFG_EDGE_RISING];
        end
    end

    // acquisition tick counter
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            tick_left <= 5'h00;
        end else if (enter_sample) begin
            tick_left <= tick_load;
        end else if (in_sample && quantize_active_tick && tick_left != 5'h00) begin
            tick_left <= tick_left - 5'h01;
        end
    end

    // trigger history
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pin_q   <= 1'b0;
            match_q <= 1'b0;
        end else begin
            pin_q   <= i_ext_irq_pin_zero;
            match_q <= timer_match;
        end
    end

    // group counting and write pointer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !module_on) begin
            seq_count <= 4'h0;
            wr_ptr    <= '0;
        end else if (buf_we && group_end) begin
            seq_count <= 4'h0;
            wr_ptr    <= '0;
        end else if (buf_we) begin
            seq_count <= seq_count + 4'h1;
            wr_ptr    <= wr_ptr + PTR_W'(1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (buf_we) begin
            result_buffer[wr_ptr] <= i_quantize_result;
        end
    end

    // converter strobe and interrupt pulse
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            quantize_start <= 1'b0;
            irq_pulse      <= 1'b0;
        end else begin
            quantize_start <= go_convert;
            irq_pulse      <= buf_we && group_end && adc_irq_enable;
        end
    end

    // read side
    wire [DATA_W-1:0] ctrl_value = {module_on, 7'h00, trigger_source_sel, 2'h0,
                                    auto_acq_enable, in_sample, in_convert};
    wire [DATA_W-1:0] cfg_value  = {3'h0, acq_tick_count, 2'h0, results_per_irq,
                                    edge_rising, adc_irq_enable};
    wire [DATA_W-1:0] stat_value = {8'h00, seq_count, wr_ptr};
    wire [DATA_W-1:0] buf_value  = DATA_W'(result_buffer[rd_idx]);
    wire [DATA_W-1:0] rd_value   = buf_hit                     ? buf_value  :
                                   (i_reg_addr == REG_CTRL)    ? ctrl_value :
                                   (i_reg_addr == REG_CFG)     ? cfg_value  :
                                   (i_reg_addr == REG_STATUS)  ? stat_value :
                                   16'h0000;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_reg_read) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd_value;
        end
    end

    assign o_reg_rdata       = rdata;
    assign o_acq_active      = in_sample;
    assign o_quantize_active = in_convert;
    assign o_quantize_start  = quantize_start;
    assign o_quantize_abort  = in_convert && !module_on;
    assign o_adc_irq         = irq_pulse;

    // checks
    logic [5:0] ticks_seen;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || enter_sample) begin
            ticks_seen <= 6'h00;
        end else if (in_sample && quantize_active_tick) begin
            ticks_seen <= ticks_seen + 6'h01;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_flags_exclusive: assert property (!(o_acq_active && o_quantize_active))
        else $error("sampling and conversion flags both set");
    a_sample_to_convert: assert property (go_convert |=> o_quantize_active && o_quantize_start)
        else $error("sampling end did not start conversion");
    a_clocked_length: assert property (in_sample && module_on && clocked_done
        |-> ({1'b0, tick_load} == 6'(ticks_seen + 6'h01)))
        else $error("clocked sampling length differs from programmed count");
    a_clocked_expire: assert property (in_sample && module_on && trigger_source_sel == SEL_CLOCKED
        && quantize_active_tick && tick_left == 5'h01 |=> o_quantize_active)
        else $error("clocked trigger did not start conversion");
    a_event_trigger: assert property (in_sample && module_on && trig_event
        |=> o_quantize_active)
        else $error("event trigger did not start conversion");
    a_ignore_busy: assert property (in_convert && module_on && !i_quantize_done
        |=> in_convert)
        else $error("conversion disturbed before completion");
    a_abort_nowrite: assert property ($fell(module_on) && $past(in_convert)
        |-> !buf_we ##1 (state == ST_IDLE))
        else $error("aborted conversion wrote or stayed busy");
    a_irq_mask: assert property (o_adc_irq |-> adc_irq_enable && $past(buf_we))
        else $error("interrupt raised while masked or without a result");
    a_irq_group: assert property (buf_we && group_end && adc_irq_enable
        |=> o_adc_irq && wr_ptr == '0)
        else $error("group end without interrupt or pointer restart");
    a_auto_restart: assert property (in_convert && i_quantize_done && module_on && auto_acq_enable
        |=> o_acq_active)
        else $error("automatic sampling did not resume");
    a_manual_stop: assert property (in_convert && i_quantize_done && !auto_acq_enable
        |=> !o_acq_active ##1 (state != ST_SAMPLE || $past(sw_set_acq)))
        else $error("sampling restarted without auto enable");
    a_sw_trigger: assert property (in_sample && module_on && sw_clr_acq
        && trigger_source_sel == SEL_SOFTWARE |=> o_quantize_active)
        else $error("software clear did not start conversion");
    a_start_pulse: assert property (o_quantize_start |-> o_quantize_active && $past(in_sample))
        else $error("start strobe outside first conversion cycle");
    a_off_idle: assert property (!module_on |=> (state == ST_IDLE))
        else $error("sequencer busy with module off");
    a_group_count: assert property (buf_we && !group_end |=> seq_count == $past(seq_count) + 4'h1)
        else $error("group count did not advance on a result");
    a_tick_reload: assert property (enter_sample |=> tick_left == $past(tick_load))
        else $error("sample counter not reloaded at sample start");
    a_auto_start: assert property (module_on && auto_acq_enable && state == ST_IDLE |=> o_acq_active)
        else $error("automatic sampling did not start from idle");

    c_free_run: cover property (in_convert && i_quantize_done && auto_acq_enable
        && trigger_source_sel == SEL_CLOCKED ##1 o_acq_active);
    c_timer_trigger: cover property (in_sample && trigger_source_sel == SEL_TIMER
        && timer_event);
    c_group_irq: cover property (o_adc_irq && results_per_irq == 4'h3);
    c_abort: cover property (o_quantize_abort);
endmodule

// file: pkg/adc_seq_pkg.sv
package adc_seq_pkg;

    // clock and conversion-clock timing
    localparam int CLOCK_PERIOD_NS      = 10;
    localparam int QUANTIZE_ACTIVE_CLOCK_PERIOD_NS = 100;
    localparam int QUANTIZE_ACTIVE_CLOCK_CYCLES    =
        (QUANTIZE_ACTIVE_CLOCK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // register port geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // register indices
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_CFG    = 5'h01;
    localparam logic [4:0] REG_STATUS = 5'h02;
    localparam logic [4:0] REG_BUF    = 5'h10;

    // control register fields
    localparam int CTRL_MODULE_ON   = 15;
    localparam int CTRL_SEL_LSB     = 5;
    localparam int CTRL_SEL_W       = 3;
    localparam int CTRL_AUTO_ACQ    = 2;
    localparam int CTRL_ACQ_ACTIVE  = 1;
    localparam int CTRL_QUANT_ACT   = 0;

    // configuration register fields
    localparam int CFG_TICK_LSB     = 8;
    localparam int CFG_TICK_W       = 5;
    localparam int CFG_RPI_LSB      = 2;
    localparam int CFG_RPI_W        = 4;
    localparam int CFG_EDGE_RISING  = 1;
    localparam int CFG_IRQ_ENABLE   = 0;

    // reset values
    localparam logic [2:0] SEL_RESET  = 3'h0;
    localparam logic [4:0] TICK_RESET = 5'h00;
    localparam logic [3:0] RPI_RESET  = 4'h0;

    // trigger source codes
    localparam logic [2:0] SEL_SOFTWARE = 3'h0;
    localparam logic [2:0] SEL_EXT_PIN  = 3'h1;
    localparam logic [2:0] SEL_TIMER    = 3'h2;
    localparam logic [2:0] SEL_PWM      = 3'h3;
    localparam logic [2:0] SEL_CLOCKED  = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } seq_state_e;

endpackage

// file: rtl/quantize_active_tick_divider.sv
`timescale 1ns/100ps
module quantize_active_tick_divider
    import adc_seq_pkg::*;
#(
    parameter int DIV = QUANTIZE_ACTIVE_CLOCK_CYCLES
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    // control
    input  wire logic i_restart,
    // tick out
    output logic      o_tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;
    wire           wrap = (count == LAST);

    generate
        if (DIV < 2) begin : g_bad_div
            $error("quantize_active_tick_divider needs DIV of at least 2");
        end
    endgenerate

    // free count restarted at each sample start
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_restart || wrap) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    assign o_tick = wrap && !i_restart;
endmodule

// file: tb/quantize_active_model.sv
`timescale 1ns/100ps
module quantize_active_model #(
    parameter int LAT = 12
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // from sequencer
    input  wire logic        i_start,
    input  wire logic        i_abort,
    // to sequencer
    output logic             o_done,
    output logic [11:0]      o_result
);
    logic        busy;
    logic [7:0]  left;
    logic [11:0] seq;
    logic [11:0] noise;

    // result lines wander outside the done cycle
    assign o_result = o_done ? seq : noise;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            busy   <= 1'b0;
            left   <= 8'h00;
            o_done <= 1'b0;
            seq    <= 12'h5A1;
            noise  <= 12'h000;
        end else begin
            noise  <= noise + 12'h3C7;
            o_done <= 1'b0;
            if (o_done) begin
                seq <= seq + 12'h123;
            end
            // abort drops the conversion, no done
            if (i_abort) begin
                busy <= 1'b0;
            end else if (i_start) begin
                busy <= 1'b1;
                left <= 8'(LAT);
            end else if (busy && left == 8'h01) begin
                busy   <= 1'b0;
                o_done <= 1'b1;
            end else if (busy) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top
    import adc_seq_pkg::*;
;
    typedef struct {
        logic [2:0] sel;
        logic       edge_r;
        logic [4:0] tick;
        int         acq_len;
    } row_s;

    localparam logic [31:0] MATCH = 32'hA5A5_0003;

    logic              i_clock;
    logic              i_sys_rst;
    logic [ADDR_W-1:0] i_reg_addr;
    logic [DATA_W-1:0] i_reg_wdata;
    logic              i_reg_write;
    logic              i_reg_read;
    logic [DATA_W-1:0] o_reg_rdata;
    logic              i_ext_irq_pin_zero;
    logic [31:0]       i_timer_pair_count;
    logic              i_pwm_special_event;
    logic              o_acq_active;
    logic              o_quantize_active;
    logic              o_quantize_start;
    logic              o_quantize_abort;
    logic              q_done;
    logic [11:0]       q_result;
    logic              o_adc_irq;
    int                bad_count;
    int                total_checks;
    int                start_cnt;
    int                abort_cnt;
    int                irq_cnt;
    int                irq_goal;
    int                done_total;
    int                acq_run;
    int                acq_len;
    int                base;
    int                n;
    logic [4:0]        done_cnt = 5'h00;
    logic [4:0]        exp_grp = 5'h01;
    logic              irq_exp_en = 1'b1;
    logic [11:0]       cap [64];
    logic [DATA_W-1:0] ctrl;
    row_s              r;
    row_s              rows [8] = '{
        '{SEL_SOFTWARE, 1'b0, 5'h01, 0},
        '{SEL_EXT_PIN,  1'b1, 5'h01, 0},
        '{SEL_EXT_PIN,  1'b0, 5'h01, 0},
        '{SEL_TIMER,    1'b0, 5'h01, 0},
        '{SEL_PWM,      1'b0, 5'h01, 0},
        '{SEL_CLOCKED,  1'b0, 5'h01, 10},
        '{SEL_CLOCKED,  1'b0, 5'h03, 30},
        '{SEL_CLOCKED,  1'b0, 5'h1F, 310}
    };

    adc_trigger_sequencer u_adc_trigger_sequencer (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
        .o_reg_rdata(o_reg_rdata), .i_ext_irq_pin_zero(i_ext_irq_pin_zero),
        .i_timer_pair_count(i_timer_pair_count), .i_timer_pair_period(MATCH),
        .i_pwm_special_event(i_pwm_special_event), .o_acq_active(o_acq_active),
        .o_quantize_active(o_quantize_active), .o_quantize_start(o_quantize_start),
        .o_quantize_abort(o_quantize_abort), .i_quantize_done(q_done),
        .i_quantize_result(q_result), .o_adc_irq(o_adc_irq));

    quantize_active_model u_quantize_active_model (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_start(o_quantize_start),
        .i_abort(o_quantize_abort), .o_done(q_done), .o_result(q_result));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // watches irq grouping, starts, aborts and sample length
    always @(posedge i_clock) begin
        if (o_adc_irq === 1'b1) begin
            `CHK({irq_exp_en, done_cnt}, {1'b1, exp_grp})
            irq_cnt++;
            done_cnt = 5'h00;
        end else if (q_done === 1'b1) begin
            done_cnt = done_cnt + 5'h01;
        end
        if (q_done === 1'b1) begin
            cap[done_total] = q_result;
            done_total++;
        end
        if (o_quantize_start === 1'b1) start_cnt++;
        if (o_quantize_abort === 1'b1) abort_cnt++;
        if (o_acq_active === 1'b1) begin
            acq_run++;
        end else if (acq_run != 0) begin
            acq_len = acq_run;
            acq_run = 0;
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clock);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        #1;
        `CHK(o_reg_rdata, e)
    endtask

    task automatic pulse_pwm();
        @(posedge i_clock);
        i_pwm_special_event <= 1'b1;
        @(posedge i_clock);
        i_pwm_special_event <= 1'b0;
    endtask

    // 0 sampling, 1 converting, 2 idle, 3 irq goal reached
    task automatic wait_on(input int which, input int limit);
        int   k;
        logic hit;
        k = 0;
        hit = 1'b0;
        while (!hit && k < limit) begin
            @(posedge i_clock);
            #1;
            k++;
            case (which)
                0: hit = (o_acq_active === 1'b1);
                1: hit = (o_quantize_active === 1'b1);
                2: hit = (o_acq_active === 1'b0) && (o_quantize_active === 1'b0);
                default: hit = (irq_cnt >= irq_goal);
            endcase
        end
        if (!hit) begin
            bad_count++;
            $display("[FAIL] t=%0t wait %0h ran out", $time, which);
            wrap_up();
        end
    endtask

    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        $display("[FAIL] t=%0t run limit reached", $time);
        wrap_up();
    end

    initial begin
        i_sys_rst = 1'b1;
        i_reg_addr = 5'h00;
        i_reg_wdata = 16'h0000;
        i_reg_write = 1'b0;
        i_reg_read = 1'b0;
        i_ext_irq_pin_zero = 1'b0;
        i_timer_pair_count = 32'hA5A5_0002;
        i_pwm_special_event = 1'b0;
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        #1;
        `CHK({o_acq_active, o_quantize_active, o_adc_irq}, 3'h0)
        rd_chk(REG_CTRL, 16'h0000);
        rd_chk(REG_CFG, 16'h0000);
        reg_wr(5'h05, 16'hFFFF);
        rd_chk(5'h05, 16'h0000);
        reg_wr(REG_STATUS, 16'hFFFF);
        rd_chk(REG_STATUS, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            ctrl = 16'h8000 | (16'(r.sel) << CTRL_SEL_LSB);
            reg_wr(REG_CTRL, 16'h0000);
            reg_wr(REG_CFG, (16'(r.tick) << CFG_TICK_LSB) |
                (16'(r.edge_r) << CFG_EDGE_RISING) | 16'h0001);
            i_ext_irq_pin_zero <= r.edge_r;
            reg_wr(REG_CTRL, ctrl);
            start_cnt = 0;
            irq_goal = irq_cnt + 1;
            reg_wr(REG_CTRL, ctrl | 16'h0002);
            wait_on(0, 10);
            rd_chk(REG_CTRL, ctrl | 16'h0002);
            if (r.acq_len == 0) begin
                i_ext_irq_pin_zero <= ~r.edge_r;
                repeat (15) @(posedge i_clock);
                #1;
                `CHK(o_quantize_active, 1'b0)
                if (r.sel == SEL_SOFTWARE) reg_wr(REG_CTRL, ctrl);
                @(posedge i_clock);
                i_ext_irq_pin_zero <= r.edge_r;
                if (r.sel == SEL_TIMER) i_timer_pair_count <= MATCH;
                @(posedge i_clock);
                i_timer_pair_count <= 32'hA5A5_0002;
                if (r.sel == SEL_PWM) pulse_pwm();
            end
            wait_on(1, 320);
            if (r.sel == SEL_PWM) pulse_pwm();
            rd_chk(REG_CTRL, ctrl | 16'h0001);
            wait_on(2, 40);
            wait_on(3, 5);
            rd_chk(REG_BUF, {4'h0, cap[done_total-1]});
            `CHK(start_cnt, 1)
            if (r.acq_len != 0) `CHK(acq_len, r.acq_len)
            $display("test source %0h edge %0h done", r.sel, r.edge_r);
        end
        // free-running groups of four, then auto cleared mid-sample
        reg_wr(REG_CTRL, 16'h0000);
        done_cnt = 5'h00;
        exp_grp = 5'h04;
        base = done_total;
        start_cnt = 0;
        irq_goal = irq_cnt + 2;
        reg_wr(REG_CFG, 16'h010D);
        reg_wr(REG_CTRL, 16'h80E4);
        wait_on(3, 400);
        reg_wr(REG_CTRL, 16'h80E2);
        wait_on(2, 60);
        repeat (30) @(posedge i_clock);
        #1;
        `CHK(start_cnt, 9)
        rd_chk(REG_STATUS, 16'h0011);
        rd_chk(REG_BUF, {4'h0, cap[base+8]});
        for (int k = 1; k < 4; k++) begin
            rd_chk(REG_BUF + 5'(k), {4'h0, cap[base+4+k]});
        end
        $display("test free running done");
        // event pulses with auto sampling, interrupt masked
        reg_wr(REG_CTRL, 16'h0000);
        done_cnt = 5'h00;
        exp_grp = 5'h02;
        irq_exp_en = 1'b0;
        start_cnt = 0;
        n = irq_cnt;
        reg_wr(REG_CFG, 16'h0004);
        reg_wr(REG_CTRL, 16'h8064);
        repeat (2) begin
            wait_on(0, 30);
            repeat (10) @(posedge i_clock);
            pulse_pwm();
            wait_on(1, 5);
        end
        wait_on(0, 30);
        `CHK(start_cnt, 2)
        `CHK(irq_cnt, n)
        rd_chk(REG_STATUS, 16'h0000);
        $display("test synced masked done");
        // abort mid-conversion
        reg_wr(REG_CTRL, 16'h0000);
        done_cnt = 5'h00;
        exp_grp = 5'h01;
        irq_exp_en = 1'b1;
        base = done_total;
        abort_cnt = 0;
        reg_wr(REG_CFG, 16'h0101);
        reg_wr(REG_CTRL, 16'h80E0);
        reg_wr(REG_CTRL, 16'h80E2);
        wait_on(1, 30);
        reg_wr(REG_CTRL, 16'h0000);
        wait_on(2, 5);
        repeat (20) @(posedge i_clock);
        #1;
        `CHK(abort_cnt, 1)
        `CHK(done_total, base)
        rd_chk(REG_BUF, {4'h0, cap[base-2]});
        rd_chk(REG_STATUS, 16'h0000);
        $display("test abort done");
        wrap_up();
    end
endmodule
